/* gpt_ext_src.sv */
// Model of the external clock, gate and 32 kHz oscillator sources that feed the timer.
`timescale 1ns/1ps
`default_nettype none
module gpt_ext_src (
    output logic ext_pin,
    output logic osc_out
);
    // ==========================================================
    // Idle levels
    // ==========================================================
    initial begin
        ext_pin = 1'b0;
        osc_out = 1'b0;
    end

    // ==========================================================
    // Waveforms, timed freely so they have no phase tie to the bus clock
    // ==========================================================
    task automatic pulses(input int n, input int half_ns);
        repeat (n) begin
            #(half_ns) ext_pin = 1'b1;
            #(half_ns) ext_pin = 1'b0;
        end
        #(half_ns);
    endtask : pulses

    task automatic gate(input int high_ns);
        #3 ext_pin = 1'b1;
        #(high_ns) ext_pin = 1'b0;
        #20;
    endtask : gate

    task automatic osc(input int n);
        repeat (n) begin
            #15625 osc_out = 1'b1;
            #15625 osc_out = 1'b0;
        end
    endtask : osc
endmodule : gpt_ext_src
`default_nettype wire

/* gpt_pkg.sv */
// Package of register offsets, field positions, reset values and timing constants for the timer.
package gpt_pkg;

    // ==========================================================
    // Register map (byte addresses, one word per register)
    // ==========================================================
    localparam logic [7:0] ADDR_COUNT = 8'h00;
    localparam logic [7:0] ADDR_PERIOD = 8'h04;
    localparam logic [7:0] ADDR_CONTROL = 8'h08;
    localparam logic [7:0] ADDR_STATUS = 8'h0C;
    localparam logic [7:0] ADDR_IRQ_EN = 8'h10;
    localparam logic [7:0] ADDR_MODE = 8'h14;

    // ==========================================================
    // Control register fields
    // ==========================================================
    localparam int CTL_TIMER_ON = 15;
    localparam int CTL_IDLE_STOP = 13;
    localparam int CTL_GATE_EN = 6;
    localparam int CTL_PRESCALE_HI = 5;
    localparam int CTL_PRESCALE_LO = 4;
    localparam int CTL_SYNC_SEL = 2;
    localparam int CTL_CLK_SRC = 1;
    localparam logic [15:0] CTL_WRITE_MASK = 16'hA076;
    localparam logic [15:0] CTL_RESET = 16'h0000;
    localparam logic [15:0] COUNT_RESET = 16'h0000;
    localparam logic [15:0] PERIOD_RESET = 16'hFFFF;

    // ==========================================================
    // Status, enable and mode fields
    // ==========================================================
    localparam int STS_MATCH = 0;
    localparam int STS_GATE_FALL = 1;
    localparam int STS_WAKE = 2;
    localparam int MODE_SEC_OSC = 0;

    // ==========================================================
    // Prescale ratios
    // ==========================================================
    localparam logic [1:0] PS_DIV1 = 2'h0;
    localparam logic [1:0] PS_DIV8 = 2'h1;
    localparam logic [1:0] PS_DIV64 = 2'h2;
    localparam logic [1:0] PS_DIV256 = 2'h3;
    localparam logic [7:0] PS_TOP_DIV8 = 8'h07;
    localparam logic [7:0] PS_TOP_DIV64 = 8'h3F;
    localparam logic [7:0] PS_TOP_DIV256 = 8'hFF;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ==========================================================
    // Timing
    // ==========================================================
    localparam int CLK_PERIOD_NS = 10;
    localparam int SYNC_STAGES = 2;

endpackage : gpt_pkg

/* gpt_timer.sv */
// 16-bit timer/counter with prescaler, gating, real-time clock use and an AXI4-Lite register slave.
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Timer mode counts instruction cycles up to period, then wraps to zero.
// - Idle with idle stop select set freezes the count; resumes after Idle.
// - Synchronous counter counts synchronized rising edges of the external clock.
// - Asynchronous counter counts every external rising edge, wrapping at period.
// - Asynchronous counter halts in Idle when idle stop select is set.
// - Gated mode counts instruction cycles only while the gate input is high.
// - A prescaler divides the selected clock by 1, 8, 64 or 256.
// - Count write, control write and reset clear the prescaler counter.
// - With the timer off the prescaler counter is not cleared.
// - Control writes keep the count; only count writes change it.
// - In Sleep counting continues only when on, external and asynchronous.
// - Counting in Sleep wraps at period and flags the match.
// - Count equal to period sets the match flag; enable drives the request.
// - Gated mode sets the flag on the gate falling edge.
// - Secondary oscillator enable, timer on and external source count oscillator rising edges.
// - Secondary oscillator enable stops normal modes and enables carry-out wake.
// - In Sleep the clock keeps counting while the oscillator runs, only with synchronization select clear.

module gpt_timer #(
    parameter int ADDR_W = 8
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic cpu_idle,
    input wire logic cpu_sleep,
    input wire logic external_clock_gate_pin,
    input wire logic osc_32k_clk,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic timer_irq,
    output logic wake_event
);

    // The register decode needs at least five address bits and reads at most eight.
    if (ADDR_W < 5 || ADDR_W > 8) begin : g_bad_addr_w
        $error("gpt_timer: ADDR_W must lie between 5 and 8");
    end

    // ==========================================================
    // Input synchronisers and edge detection
    // ==========================================================
    logic [1:0] ext_sync_ff, osc_sync_ff, cpu_sync_ff, slp_sync_ff;
    logic ext_last_ff, osc_last_ff;
    logic [1:0] nxt_ext_sync, nxt_osc_sync, nxt_cpu_sync, nxt_slp_sync;
    logic nxt_ext_last, nxt_osc_last;
    logic ext_rise, ext_fall, osc_rise, idle_s, sleep_s;

    always_comb begin
        nxt_ext_sync = {ext_sync_ff[0], external_clock_gate_pin};
        nxt_osc_sync = {osc_sync_ff[0], osc_32k_clk};
        nxt_cpu_sync = {cpu_sync_ff[0], cpu_idle};
        nxt_slp_sync = {slp_sync_ff[0], cpu_sleep};
        nxt_ext_last = ext_sync_ff[1];
        nxt_osc_last = osc_sync_ff[1];
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            ext_sync_ff <= 2'h0;
            osc_sync_ff <= 2'h0;
            cpu_sync_ff <= 2'h0;
            slp_sync_ff <= 2'h0;
            ext_last_ff <= 1'b0;
            osc_last_ff <= 1'b0;
        end else begin
            ext_sync_ff <= nxt_ext_sync;
            osc_sync_ff <= nxt_osc_sync;
            cpu_sync_ff <= nxt_cpu_sync;
            slp_sync_ff <= nxt_slp_sync;
            ext_last_ff <= nxt_ext_last;
            osc_last_ff <= nxt_osc_last;
        end
    end

    // The asynchronous counter is modelled by the same two-stage capture, as there is one clock.
    assign ext_rise = ext_sync_ff[1] & ~ext_last_ff;
    assign ext_fall = ~ext_sync_ff[1] & ext_last_ff;
    assign osc_rise = osc_sync_ff[1] & ~osc_last_ff;
    assign idle_s = cpu_sync_ff[1];
    assign sleep_s = slp_sync_ff[1];

    // ==========================================================
    // Registers and bus slave state
    // ==========================================================
    logic [15:0] count_ff, period_ff, ctl_ff;
    logic [15:0] nxt_count, nxt_period, nxt_ctl;
    logic [7:0] ps_ff, nxt_ps;
    logic match_ff, gfall_ff, wake_ff, irq_en_ff, sec_osc_ff;
    logic nxt_match, nxt_gfall, nxt_wake, nxt_irq_en, nxt_sec_osc;
    logic irq_ff, nxt_irq, wake_out_ff, nxt_wake_out;
    logic aw_ff, w_ff, bv_ff, ar_ff, rv_ff, awrdy_ff, wrdy_ff;
    logic nxt_aw, nxt_w, nxt_bv, nxt_rv, nxt_awrdy, nxt_wrdy, nxt_arrdy;
    logic [ADDR_W-1:0] awa_ff, nxt_awa;
    logic [31:0] wd_ff, nxt_wd, rd_ff, nxt_rd;
    logic [1:0] bresp_ff, nxt_bresp, rresp_ff, nxt_rresp;

    logic on, ext_src, sync_sel, gate_en, idle_stop;
    logic [1:0] ps_sel;
    logic [7:0] ps_top;
    logic tick, run, ps_done, at_period, wr_go;
    logic wr_count, wr_period, wr_ctl, wr_sts, wr_en, wr_mode;
    logic [7:0] wa, ra;

    assign on = ctl_ff[gpt_pkg::CTL_TIMER_ON];
    assign ext_src = ctl_ff[gpt_pkg::CTL_CLK_SRC];
    assign sync_sel = ctl_ff[gpt_pkg::CTL_SYNC_SEL];
    assign gate_en = ctl_ff[gpt_pkg::CTL_GATE_EN];
    assign idle_stop = ctl_ff[gpt_pkg::CTL_IDLE_STOP];
    assign ps_sel = ctl_ff[gpt_pkg::CTL_PRESCALE_HI:gpt_pkg::CTL_PRESCALE_LO];

    always_comb begin
        case (ps_sel)
            gpt_pkg::PS_DIV1: ps_top = 8'h00;
            gpt_pkg::PS_DIV8: ps_top = gpt_pkg::PS_TOP_DIV8;
            gpt_pkg::PS_DIV64: ps_top = gpt_pkg::PS_TOP_DIV64;
            default: ps_top = gpt_pkg::PS_TOP_DIV256;
        endcase
    end

    always_comb begin
        // Source clock edge selection.
        if (!ext_src) begin
            tick = gate_en ? ext_sync_ff[1] : 1'b1;
        end else if (sec_osc_ff) begin
            tick = osc_rise;
        end else begin
            tick = ext_rise;
        end
        // Run gating by power state.
        run = on;
        if (sec_osc_ff && !ext_src) begin
            run = 1'b0;
        end
        if (idle_s && idle_stop) begin
            run = 1'b0;
        end
        if (sleep_s && !(ext_src && !sync_sel)) begin
            run = 1'b0;
        end
    end

    assign ps_done = (ps_ff == ps_top);
    assign at_period = (count_ff == period_ff);
    assign wr_go = aw_ff && w_ff && !bv_ff;
    assign wa = 8'(awa_ff) & 8'hFC;
    assign ra = 8'(s_axi_araddr) & 8'hFC;
    assign wr_count = wr_go && wa == gpt_pkg::ADDR_COUNT;
    assign wr_period = wr_go && wa == gpt_pkg::ADDR_PERIOD;
    assign wr_ctl = wr_go && wa == gpt_pkg::ADDR_CONTROL;
    assign wr_sts = wr_go && wa == gpt_pkg::ADDR_STATUS;
    assign wr_en = wr_go && wa == gpt_pkg::ADDR_IRQ_EN;
    assign wr_mode = wr_go && wa == gpt_pkg::ADDR_MODE;

    // ==========================================================
    // Counter, prescaler and flags
    // ==========================================================
    always_comb begin
        nxt_count = count_ff;
        nxt_ps = ps_ff;
        nxt_period = period_ff;
        nxt_ctl = ctl_ff;
        nxt_irq_en = irq_en_ff;
        nxt_sec_osc = sec_osc_ff;
        nxt_match = match_ff;
        nxt_gfall = gfall_ff;
        nxt_wake = wake_ff;
        if (run && tick) begin
            nxt_ps = ps_done ? 8'h00 : ps_ff + 8'h01;
            if (ps_done) begin
                nxt_count = at_period ? 16'h0000 : count_ff + 16'h0001;
            end
        end
        // Software clears flags by writing ones; a same-cycle event still sets them.
        if (wr_sts) begin
            nxt_match = match_ff & ~wd_ff[gpt_pkg::STS_MATCH];
            nxt_gfall = gfall_ff & ~wd_ff[gpt_pkg::STS_GATE_FALL];
            nxt_wake = wake_ff & ~wd_ff[gpt_pkg::STS_WAKE];
        end
        if (run && tick && ps_done && at_period) begin
            nxt_match = 1'b1;
            if (sec_osc_ff) begin
                nxt_wake = 1'b1;
            end
        end
        if (on && gate_en && !ext_src && ext_fall) begin
            nxt_gfall = 1'b1;
        end
        if (wr_count) begin
            nxt_count = wd_ff[15:0];
        end
        if ((wr_count || wr_ctl) && on) begin
            nxt_ps = 8'h00;
        end
        if (wr_ctl) begin
            nxt_ctl = wd_ff[15:0] & gpt_pkg::CTL_WRITE_MASK;
        end
        if (wr_period) begin
            nxt_period = wd_ff[15:0];
        end
        if (wr_en) begin
            nxt_irq_en = wd_ff[0];
        end
        if (wr_mode) begin
            nxt_sec_osc = wd_ff[gpt_pkg::MODE_SEC_OSC];
        end
        nxt_irq = irq_en_ff && (match_ff || gfall_ff);
        nxt_wake_out = wake_ff;
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            count_ff <= gpt_pkg::COUNT_RESET;
            period_ff <= gpt_pkg::PERIOD_RESET;
            ctl_ff <= gpt_pkg::CTL_RESET;
            ps_ff <= 8'h00;
            irq_en_ff <= 1'b0;
            sec_osc_ff <= 1'b0;
            match_ff <= 1'b0;
            gfall_ff <= 1'b0;
            wake_ff <= 1'b0;
            irq_ff <= 1'b0;
            wake_out_ff <= 1'b0;
        end else begin
            count_ff <= nxt_count;
            period_ff <= nxt_period;
            ctl_ff <= nxt_ctl;
            ps_ff <= nxt_ps;
            irq_en_ff <= nxt_irq_en;
            sec_osc_ff <= nxt_sec_osc;
            match_ff <= nxt_match;
            gfall_ff <= nxt_gfall;
            wake_ff <= nxt_wake;
            irq_ff <= nxt_irq;
            wake_out_ff <= nxt_wake_out;
        end
    end

    assign timer_irq = irq_ff;
    assign wake_event = wake_out_ff;

    // ==========================================================
    // AXI4-Lite slave
    // ==========================================================
    always_comb begin
        nxt_aw = aw_ff;
        nxt_w = w_ff;
        nxt_awa = awa_ff;
        nxt_wd = wd_ff;
        nxt_bv = bv_ff;
        nxt_bresp = bresp_ff;
        nxt_rv = rv_ff;
        nxt_rd = rd_ff;
        nxt_rresp = rresp_ff;
        if (s_axi_awvalid && awrdy_ff) begin
            nxt_aw = 1'b1;
            nxt_awa = s_axi_awaddr;
        end
        if (s_axi_wvalid && wrdy_ff) begin
            nxt_w = 1'b1;
            nxt_wd = s_axi_wdata;
        end
        if (wr_go) begin
            nxt_bv = 1'b1;
            nxt_aw = 1'b0;
            nxt_w = 1'b0;
            nxt_bresp = (wa > gpt_pkg::ADDR_MODE) ? gpt_pkg::RESP_SLVERR : gpt_pkg::RESP_OKAY;
        end
        if (bv_ff && s_axi_bready) begin
            nxt_bv = 1'b0;
        end
        if (s_axi_arvalid && ar_ff) begin
            nxt_rv = 1'b1;
            nxt_rresp = gpt_pkg::RESP_OKAY;
            case (ra)
                gpt_pkg::ADDR_COUNT: nxt_rd = {16'h0000, count_ff};
                gpt_pkg::ADDR_PERIOD: nxt_rd = {16'h0000, period_ff};
                gpt_pkg::ADDR_CONTROL: nxt_rd = {16'h0000, ctl_ff};
                gpt_pkg::ADDR_STATUS: nxt_rd = {29'h0, wake_ff, gfall_ff, match_ff};
                gpt_pkg::ADDR_IRQ_EN: nxt_rd = {31'h0, irq_en_ff};
                gpt_pkg::ADDR_MODE: nxt_rd = {31'h0, sec_osc_ff};
                default: begin
                    nxt_rd = 32'h0;
                    nxt_rresp = gpt_pkg::RESP_SLVERR;
                end
            endcase
        end else if (rv_ff && s_axi_rready) begin
            nxt_rv = 1'b0;
        end
        // Ready outputs are registered so that they come straight from flip-flops.
        nxt_awrdy = !nxt_aw;
        nxt_wrdy = !nxt_w;
        nxt_arrdy = !nxt_rv;
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            aw_ff <= 1'b0;
            w_ff <= 1'b0;
            awa_ff <= '0;
            wd_ff <= 32'h0;
            bv_ff <= 1'b0;
            bresp_ff <= 2'h0;
            ar_ff <= 1'b0;
            awrdy_ff <= 1'b0;
            wrdy_ff <= 1'b0;
            rv_ff <= 1'b0;
            rd_ff <= 32'h0;
            rresp_ff <= 2'h0;
        end else begin
            aw_ff <= nxt_aw;
            w_ff <= nxt_w;
            awa_ff <= nxt_awa;
            wd_ff <= nxt_wd;
            bv_ff <= nxt_bv;
            bresp_ff <= nxt_bresp;
            ar_ff <= nxt_arrdy;
            awrdy_ff <= nxt_awrdy;
            wrdy_ff <= nxt_wrdy;
            rv_ff <= nxt_rv;
            rd_ff <= nxt_rd;
            rresp_ff <= nxt_rresp;
        end
    end

    assign s_axi_awready = awrdy_ff;
    assign s_axi_wready = wrdy_ff;
    assign s_axi_bvalid = bv_ff;
    assign s_axi_bresp = bresp_ff;
    assign s_axi_arready = ar_ff;
    assign s_axi_rvalid = rv_ff;
    assign s_axi_rdata = rd_ff;
    assign s_axi_rresp = rresp_ff;

    // ==========================================================
    // Checks
    // ==========================================================
    chk_count_wrap: assert property (@(posedge clk) disable iff (reset)
        (run && tick && ps_done && at_period && !wr_count) |=> count_ff == 16'h0000)
        else $error("count did not wrap at period");
    chk_idle_freeze: assert property (@(posedge clk) disable iff (reset)
        (idle_s && idle_stop && !wr_count) |=> $stable(count_ff))
        else $error("count moved while frozen in idle");
    chk_match_set: assert property (@(posedge clk) disable iff (reset)
        (run && tick && ps_done && at_period) |=> match_ff)
        else $error("match flag not set");
    chk_match_sticky: assert property (@(posedge clk) disable iff (reset)
        (match_ff && !wr_sts) |=> match_ff)
        else $error("match flag cleared by hardware");
    chk_ctl_keeps: assert property (@(posedge clk) disable iff (reset)
        (wr_ctl && !run) |=> $stable(count_ff))
        else $error("control write changed count");
    chk_ps_clear: assert property (@(posedge clk) disable iff (reset)
        (wr_count && on) |=> ps_ff == 8'h00)
        else $error("prescaler not cleared");
    chk_ps_hold: assert property (@(posedge clk) disable iff (reset)
        (!on) |=> $stable(ps_ff))
        else $error("prescaler moved while off");
    chk_sleep_stop: assert property (@(posedge clk) disable iff (reset)
        (sleep_s && !ext_src && !wr_count) |=> $stable(count_ff))
        else $error("count ran in sleep on internal clock");
    chk_gate_fall: assert property (@(posedge clk) disable iff (reset)
        (on && gate_en && !ext_src && ext_fall) |=> gfall_ff)
        else $error("gate fall flag not set");
    chk_irq_out: assert property (@(posedge clk) disable iff (reset)
        (irq_en_ff && match_ff) |=> timer_irq)
        else $error("interrupt not raised");

endmodule : gpt_timer
`default_nettype wire

/* tb.sv */
// Self-checking testbench for the timer block and its register slave.
`timescale 1ns/1ps
`default_nettype none
module tb;
    typedef struct {
        string name;
        logic [31:0] lo;
        logic [31:0] hi;
        logic [1:0] resp;
    } gpt_exp_s;
    logic clk, reset, cpu_idle, cpu_sleep, ext_pin, osc;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, timer_irq, wake_event;
    logic [1:0] bresp, rresp, last_bresp;
    int fails, total_checks, seed, n;
    int ratio [4] = '{1, 8, 64, 256};
    gpt_exp_s expq[$];
    gpt_exp_s mon_e;

    gpt_timer dut (.clk(clk), .reset(reset), .cpu_idle(cpu_idle), .cpu_sleep(cpu_sleep),
        .external_clock_gate_pin(ext_pin), .osc_32k_clk(osc), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .timer_irq(timer_irq), .wake_event(wake_event));
    gpt_ext_src src (.ext_pin(ext_pin), .osc_out(osc));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // ==========================================================
    // Checking and closing
    // ==========================================================
    task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask : check

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : print_verdict

    // Read answers are matched against the oldest noted expectation.
    always @(negedge clk) begin
        if (rvalid === 1'b1 && rready === 1'b1) begin
            mon_e = expq.pop_front();
            total_checks++;
            if (((rdata >= mon_e.lo) && (rdata <= mon_e.hi) && (rresp === mon_e.resp)) !== 1'b1) begin
                fails++;
                $display("Error %s expected %h..%h seen %h", mon_e.name, mon_e.lo, mon_e.hi, rdata);
            end
        end
    end

    initial begin
        #600000;
        fails++;
        $display("Error watchdog expected finish seen timeout");
        print_verdict();
    end

    // ==========================================================
    // Bus master tasks
    // ==========================================================
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int k;
        logic aw_hit, w_hit, b_hit;
        k = 0;
        b_hit = 1'b0;
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!b_hit && k < 200) begin
            @(negedge clk);
            aw_hit = awvalid && awready;
            w_hit = wvalid && wready;
            b_hit = bvalid && bready;
            if (b_hit) last_bresp = bresp;
            @(posedge clk);
            if (aw_hit) awvalid <= 1'b0;
            if (w_hit) wvalid <= 1'b0;
            if (b_hit) bready <= 1'b0;
            k++;
        end
        if (!b_hit) check("write response", 32'h1, 32'h0);
    endtask : wr

    task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] lo,
                      input logic [31:0] hi, input logic [1:0] rsp = gpt_pkg::RESP_OKAY);
        int k;
        logic ar_hit, r_hit;
        k = 0;
        r_hit = 1'b0;
        expq.push_back('{nm, lo, hi, rsp});
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!r_hit && k < 200) begin
            @(negedge clk);
            ar_hit = arvalid && arready;
            r_hit = rvalid && rready;
            @(posedge clk);
            if (ar_hit) arvalid <= 1'b0;
            if (r_hit) rready <= 1'b0;
            k++;
        end
        if (!r_hit) check("read response", 32'h1, 32'h0);
    endtask : rd

    // Counts random external edges under one control setting; mod gives the wrap.
    task automatic ext_case(input string nm, input logic [31:0] ctl, input int mult, input int md);
        wr(gpt_pkg::ADDR_CONTROL, ctl);
        wr(gpt_pkg::ADDR_COUNT, 32'h0);
        n = 3 + ($unsigned($random(seed)) % 8);
        src.pulses(n, 43);
        repeat (10) @(posedge clk);
        rd(nm, gpt_pkg::ADDR_COUNT, (n * mult) % md, (n * mult) % md);
        wr(gpt_pkg::ADDR_CONTROL, 32'h0);
    endtask : ext_case

    // ==========================================================
    // Main sequence
    // ==========================================================
    initial begin
        seed = 93;
        fails = 0;
        total_checks = 0;
        {reset, cpu_idle, cpu_sleep} = 3'b100;
        {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
        awaddr = 8'h00;
        araddr = 8'h00;
        wdata = 32'h0;
        repeat (4) @(posedge clk);
        reset <= 1'b0;
        rd("count reset", gpt_pkg::ADDR_COUNT, 32'h0, 32'h0);
        rd("period reset", gpt_pkg::ADDR_PERIOD, 32'hFFFF, 32'hFFFF);
        rd("control reset", gpt_pkg::ADDR_CONTROL, 32'h0, 32'h0);
        rd("status reset", gpt_pkg::ADDR_STATUS, 32'h0, 32'h0);
        rd("unmapped", 8'h18, 32'h0, 32'h0, gpt_pkg::RESP_SLVERR);
        wr(8'h18, 32'h1234);
        check("unmapped bresp", {30'h0, gpt_pkg::RESP_SLVERR}, {30'h0, last_bresp});
        $display("test reset and map done");
        wr(gpt_pkg::ADDR_CONTROL, 32'hFFFFFFFF);
        rd("control mask", gpt_pkg::ADDR_CONTROL, {16'h0, gpt_pkg::CTL_WRITE_MASK},
           {16'h0, gpt_pkg::CTL_WRITE_MASK});
        n = $random(seed) & 32'hFFFF;
        wr(gpt_pkg::ADDR_COUNT, n);
        wr(gpt_pkg::ADDR_CONTROL, 32'h0);
        rd("count kept", gpt_pkg::ADDR_COUNT, n, n);
        $display("test control fields done");
        for (int c = 0; c < 4; c++) begin
            wr(gpt_pkg::ADDR_COUNT, 32'h0);
            wr(gpt_pkg::ADDR_CONTROL, 32'h8000 | (c << 4));
            repeat (512) @(posedge clk);
            wr(gpt_pkg::ADDR_CONTROL, c << 4);
            rd("prescale", gpt_pkg::ADDR_COUNT, (512 / ratio[c]) - 1, (520 / ratio[c]) + 2);
        end
        wr(gpt_pkg::ADDR_COUNT, 32'h0);
        repeat (10) wr(gpt_pkg::ADDR_CONTROL, 32'h8010);
        wr(gpt_pkg::ADDR_CONTROL, 32'h0010);
        rd("prescaler cleared", gpt_pkg::ADDR_COUNT, 32'h0, 32'h0);
        $display("test prescaler done");
        wr(gpt_pkg::ADDR_PERIOD, 32'h5);
        wr(gpt_pkg::ADDR_CONTROL, 32'h8000);
        repeat (40) @(posedge clk);
        rd("count wrap", gpt_pkg::ADDR_COUNT, 32'h0, 32'h5);
        rd("match flag", gpt_pkg::ADDR_STATUS, 32'h1, 32'h1);
        wr(gpt_pkg::ADDR_IRQ_EN, 32'h1);
        repeat (2) @(posedge clk);
        check("irq on match", 32'h1, {31'h0, timer_irq});
        wr(gpt_pkg::ADDR_CONTROL, 32'h0);
        wr(gpt_pkg::ADDR_COUNT, 32'h0);
        wr(gpt_pkg::ADDR_STATUS, 32'h7);
        rd("flag cleared", gpt_pkg::ADDR_STATUS, 32'h0, 32'h0);
        check("irq cleared", 32'h0, {31'h0, timer_irq});
        wr(gpt_pkg::ADDR_PERIOD, 32'hFFFF);
        $display("test period match done");
        cpu_idle <= 1'b1;
        wr(gpt_pkg::ADDR_CONTROL, 32'hA000);
        wr(gpt_pkg::ADDR_COUNT, 32'd100);
        repeat (50) @(posedge clk);
        rd("idle freeze", gpt_pkg::ADDR_COUNT, 32'd100, 32'd100);
        wr(gpt_pkg::ADDR_CONTROL, 32'h8000);
        repeat (50) @(posedge clk);
        rd("idle run", gpt_pkg::ADDR_COUNT, 32'd145, 32'd170);
        ext_case("async idle", 32'hA002, 0, 65536);
        cpu_idle <= 1'b0;
        ext_case("sync count", 32'h8006, 1, 65536);
        ext_case("async count", 32'h8002, 1, 65536);
        $display("test idle and counters done");
        cpu_sleep <= 1'b1;
        ext_case("sleep async", 32'h8002, 1, 65536);
        ext_case("sleep sync", 32'h8006, 0, 65536);
        ext_case("sleep internal", 32'h8000, 0, 65536);
        wr(gpt_pkg::ADDR_PERIOD, 32'h3);
        ext_case("sleep wrap", 32'h8002, 1, 4);
        rd("sleep match", gpt_pkg::ADDR_STATUS, (n > 3) ? 32'h1 : 32'h0,
           (n > 3) ? 32'h1 : 32'h0);
        cpu_sleep <= 1'b0;
        wr(gpt_pkg::ADDR_PERIOD, 32'hFFFF);
        wr(gpt_pkg::ADDR_STATUS, 32'h7);
        $display("test sleep done");
        wr(gpt_pkg::ADDR_COUNT, 32'h0);
        wr(gpt_pkg::ADDR_CONTROL, 32'h8040);
        src.gate(300);
        repeat (10) @(posedge clk);
        rd("gated count", gpt_pkg::ADDR_COUNT, 32'd25, 32'd35);
        rd("gate fall flag", gpt_pkg::ADDR_STATUS, 32'h2, 32'h2);
        check("irq on gate fall", 32'h1, {31'h0, timer_irq});
        wr(gpt_pkg::ADDR_CONTROL, 32'h0);
        wr(gpt_pkg::ADDR_STATUS, 32'h7);
        $display("test gating done");
        wr(gpt_pkg::ADDR_MODE, 32'h1);
        wr(gpt_pkg::ADDR_COUNT, 32'hFFFE);
        wr(gpt_pkg::ADDR_CONTROL, 32'h8002);
        src.osc(3);
        repeat (10) @(posedge clk);
        rd("clock count", gpt_pkg::ADDR_COUNT, 32'h1, 32'h1);
        check("wake on carry", 32'h1, {31'h0, wake_event});
        wr(gpt_pkg::ADDR_CONTROL, 32'h8000);
        wr(gpt_pkg::ADDR_COUNT, 32'h0);
        repeat (30) @(posedge clk);
        rd("timer mode off", gpt_pkg::ADDR_COUNT, 32'h0, 32'h0);
        $display("test real-time clock done");
        print_verdict();
    end
endmodule : tb
`default_nettype wire
